//--- core/pmbus_link_consts.svh
// Timing constants for the power management bus master link
`ifndef PMBUS_LINK_CONSTS_SVH
`define PMBUS_LINK_CONSTS_SVH

// System clock period
`define PML_CLK_NS        10

// Quarter of a serial clock period for each bus speed
`define PML_Q100_NS       2500
`define PML_Q400_NS       625
`define PML_Q1M_NS        250

// Quarter period in system clocks, rounded up
`define PML_Q100_CYC      ((`PML_Q100_NS + `PML_CLK_NS - 1) / `PML_CLK_NS)
`define PML_Q400_CYC      ((`PML_Q400_NS + `PML_CLK_NS - 1) / `PML_CLK_NS)
`define PML_Q1M_CYC       ((`PML_Q1M_NS + `PML_CLK_NS - 1) / `PML_CLK_NS)

// Gap between byte events that counts as a timeout
`define PML_TOUT_MS       25
`define PML_TOUT_CYC      (`PML_TOUT_MS * 1000000 / `PML_CLK_NS)

// Widths of the quarter and timeout counters
`define PML_QCNT_W        9
`define PML_TCNT_W        22

// Transmit FIFO shape
`define PML_FIFO_WIDTH    8
`define PML_FIFO_DEPTH    16

`endif

//--- core/pmbus_link_pkg.sv
// Types shared by the power management bus master link
package pmbus_link_pkg;

   typedef enum logic [1:0] {
      SPD_100K = 2'h0,
      SPD_400K = 2'h1,
      SPD_1M   = 2'h2
   } speed_t;

   typedef enum logic [1:0] {
      CMD_START  = 2'h0,
      CMD_RSTART = 2'h1,
      CMD_BYTE   = 2'h2,
      CMD_STOP   = 2'h3
   } cmd_t;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_COND = 4'h2,
      ST_BYTE = 4'h4,
      ST_STOP = 4'h8
   } state_t;

endpackage : pmbus_link_pkg

//--- core/link_fifo.sv
// Flip-flop FIFO with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none

module link_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic             mclk,
   input  wire logic             sys_rst,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output var  logic             in_ready,
   output var  logic [WIDTH-1:0] out_data,
   output var  logic             out_valid,
   input  wire logic             out_ready
);

   // Depth must be a power of two so the pointers wrap naturally
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [CW-1:0]    count;
   logic [CW-1:0]    next_count;
   wire              push;
   wire              pop;

   assign push       = in_valid && in_ready;
   assign pop        = out_valid && out_ready;
   assign next_count = count + CW'(push) - CW'(pop);

   always_comb begin
      out_data = mem[rd_ptr];
   end

   generate
      for (genvar i = 0; i < DEPTH; i++) begin : g_entry
         always_ff @(posedge mclk) begin
            if (push && wr_ptr == AW'(i)) begin
               mem[i] <= in_data;
            end
         end
      end
   endgenerate

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         wr_ptr    <= '0;
         rd_ptr    <= '0;
         count     <= '0;
         in_ready  <= 1'b0;
         out_valid <= 1'b0;
      end else begin
         wr_ptr    <= wr_ptr + AW'(push);
         rd_ptr    <= rd_ptr + AW'(pop);
         count     <= next_count;
         in_ready  <= next_count != CW'(DEPTH);
         out_valid <= next_count != '0;
      end
   end

endmodule : link_fifo

`default_nettype wire

//--- core/pmbus_master_link.sv
// Power management bus master link layer with byte engine and timeout
`timescale 1ns/100ps
`default_nettype none
`include "pmbus_link_consts.svh"

// Overview of operation
// - The serial clock runs at 100 kHz, 400 kHz or 1 MHz as bus_speed selects.
// - On command the master makes a start, repeated start or stop, or moves a byte.
// - Pulses tell the transaction layer of send done, receive done and errors.
// - A slave not-acknowledge after a sent byte raises the NACK error.
// - A gap of 25 ms or more between byte events raises the timeout error.
// - Each byte event restarts the timeout, so a clock held low times out.
// - A CONTROL input is sampled and turned into an on or off indication.
// - The active level of CONTROL is set by an input driven from bus commands.
// - An alert line from the slaves is sampled and shown as an interrupt request.
// - Bytes after a start are written; after a repeated start and address, read.
module pmbus_master_link
   import pmbus_link_pkg::*;
#(
   parameter int TIMEOUT_CYCLES = `PML_TOUT_CYC
) (
   input  wire logic       mclk,
   input  wire logic       sys_rst,
   input  wire logic [1:0] bus_speed,
   input  wire logic       cmd_valid,
   input  wire logic [1:0] cmd,
   input  wire logic       cmd_last,
   output var  logic       cmd_ready,
   input  wire logic [7:0] tx_data,
   input  wire logic       tx_valid,
   output var  logic       tx_ready,
   output var  logic [7:0] rx_data,
   output var  logic       recv_done,
   output var  logic       send_done,
   output var  logic       err_nack,
   output var  logic       err_timeout,
   output var  logic       bus_active,
   input  wire logic       scl_in,
   output var  logic       scl_out,
   output var  logic       scl_oe,
   input  wire logic       sda_in,
   output var  logic       sda_out,
   output var  logic       sda_oe,
   input  wire logic       control_in,
   input  wire logic       control_pol,
   output var  logic       control_on,
   input  wire logic       smbalert_n_in,
   output var  logic       alert
);

   localparam int QW = `PML_QCNT_W;
   localparam int TW = `PML_TCNT_W;

   state_t        state;
   logic [1:0]    q;
   logic [QW-1:0] qcnt;
   logic [3:0]    bit_idx;
   logic [7:0]    shreg;
   logic          rd_phase;
   logic          addr_done;
   logic          xfer_rd;
   logic          ack_last;
   logic          nack_seen;
   logic [TW-1:0] tcnt;

   // Synchronisers for pins
   logic          scl_m;
   logic          scl_s;
   logic          sda_m;
   logic          sda_s;
   logic          ctl_m;
   logic          ctl_s;
   logic          alr_m;
   logic          alr_s;

   // FIFO drain side
   logic [7:0]    fifo_data;
   logic          fifo_valid;

   wire [QW-1:0]  qlen;
   wire           stall;
   wire           tick;
   wire           byte_rd_next;
   wire           take;
   wire           pop;
   wire           byte_evt;
   wire           tout_hit;
   wire           last_bit;

   link_fifo #(
      .WIDTH (`PML_FIFO_WIDTH),
      .DEPTH (`PML_FIFO_DEPTH)
   ) u_tx_fifo (
      .mclk      (mclk),
      .sys_rst   (sys_rst),
      .in_data   (tx_data),
      .in_valid  (tx_valid),
      .in_ready  (tx_ready),
      .out_data  (fifo_data),
      .out_valid (fifo_valid),
      .out_ready (pop)
   );

   // Quarter period per speed; unknown code falls back to 100 kHz
   assign qlen = (bus_speed == SPD_400K) ? QW'(`PML_Q400_CYC - 1) :
                 (bus_speed == SPD_1M)   ? QW'(`PML_Q1M_CYC - 1)  :
                                           QW'(`PML_Q100_CYC - 1);

   // Slave stretching holds the quarter until the clock line is high
   assign stall    = (state != ST_IDLE) && (q == 2'd2) && !scl_s;
   assign tick     = (state != ST_IDLE) && (qcnt == '0) && !stall;
   assign last_bit = bit_idx == 4'd8;
   assign byte_evt = (state == ST_BYTE) && tick && (q == 2'd3) && last_bit;

   assign byte_rd_next = rd_phase && addr_done;
   assign take = cmd_valid && cmd_ready &&
                 (cmd != CMD_BYTE || byte_rd_next || fifo_valid);
   assign pop  = take && (cmd == CMD_BYTE) && !byte_rd_next;

   assign tout_hit = bus_active && (tcnt == TW'(TIMEOUT_CYCLES - 1));

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         scl_m <= 1'b1;
         scl_s <= 1'b1;
         sda_m <= 1'b1;
         sda_s <= 1'b1;
         ctl_m <= 1'b0;
         ctl_s <= 1'b0;
         alr_m <= 1'b1;
         alr_s <= 1'b1;
      end else begin
         scl_m <= scl_in;
         scl_s <= scl_m;
         sda_m <= sda_in;
         sda_s <= sda_m;
         ctl_m <= control_in;
         ctl_s <= ctl_m;
         alr_m <= smbalert_n_in;
         alr_s <= alr_m;
      end
   end

   // Optional pins
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         control_on <= 1'b0;
         alert      <= 1'b0;
      end else begin
         control_on <= ctl_s == control_pol;
         alert      <= !alr_s;
      end
   end

   // Open-drain pins only ever pull low
   always_ff @(posedge mclk) begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
   end

   always_ff @(posedge mclk) begin
      if (sys_rst || state == ST_IDLE || tick) begin
         qcnt <= qlen;
      end else if (qcnt != '0) begin
         qcnt <= qcnt - QW'(1);
      end
   end

   // Gap monitor between byte events
   always_ff @(posedge mclk) begin
      if (sys_rst || !bus_active || byte_evt || tout_hit) begin
         tcnt <= '0;
      end else begin
         tcnt <= tcnt + TW'(1);
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         state       <= ST_IDLE;
         q           <= 2'd0;
         bit_idx     <= 4'd0;
         shreg       <= 8'h00;
         rd_phase    <= 1'b0;
         addr_done   <= 1'b0;
         xfer_rd     <= 1'b0;
         ack_last    <= 1'b0;
         nack_seen   <= 1'b0;
         bus_active  <= 1'b0;
         cmd_ready   <= 1'b1;
         rx_data     <= 8'h00;
         recv_done   <= 1'b0;
         send_done   <= 1'b0;
         err_nack    <= 1'b0;
         err_timeout <= 1'b0;
         scl_oe      <= 1'b0;
         sda_oe      <= 1'b0;
      end else begin
         recv_done   <= 1'b0;
         send_done   <= 1'b0;
         err_nack    <= 1'b0;
         err_timeout <= 1'b0;
         if (tout_hit) begin
            err_timeout <= 1'b1;
            q           <= 2'd0;
            if (state == ST_STOP) begin
               // Stop itself is stuck: let go of the lines
               state      <= ST_IDLE;
               bus_active <= 1'b0;
               scl_oe     <= 1'b0;
               sda_oe     <= 1'b0;
               cmd_ready  <= 1'b1;
            end else begin
               state     <= ST_STOP;
               cmd_ready <= 1'b0;
            end
         end else begin
            case (state)
               ST_IDLE: begin
                  if (take) begin
                     cmd_ready <= 1'b0;
                     q         <= 2'd0;
                     case (cmd)
                        CMD_START: begin
                           rd_phase   <= 1'b0;
                           addr_done  <= 1'b0;
                           bus_active <= 1'b1;
                           state      <= ST_COND;
                        end
                        CMD_RSTART: begin
                           rd_phase   <= 1'b1;
                           addr_done  <= 1'b0;
                           bus_active <= 1'b1;
                           state      <= ST_COND;
                        end
                        CMD_BYTE: begin
                           xfer_rd  <= byte_rd_next;
                           ack_last <= cmd_last;
                           bit_idx  <= 4'd0;
                           shreg    <= byte_rd_next ? 8'h00 : fifo_data;
                           state    <= ST_BYTE;
                        end
                        default: begin
                           state <= ST_STOP;
                        end
                     endcase
                  end
               end
               ST_COND: begin
                  if (tick) begin
                     q <= q + 2'd1;
                     case (q)
                        2'd0: sda_oe <= 1'b0;
                        2'd1: scl_oe <= 1'b0;
                        2'd2: sda_oe <= 1'b1;
                        default: begin
                           scl_oe    <= 1'b1;
                           state     <= ST_IDLE;
                           cmd_ready <= 1'b1;
                        end
                     endcase
                  end
               end
               ST_STOP: begin
                  if (tick) begin
                     q <= q + 2'd1;
                     case (q)
                        2'd0: sda_oe <= 1'b1;
                        2'd1: scl_oe <= 1'b0;
                        2'd2: sda_oe <= 1'b0;
                        default: begin
                           state      <= ST_IDLE;
                           bus_active <= 1'b0;
                           cmd_ready  <= 1'b1;
                        end
                     endcase
                  end
               end
               ST_BYTE: begin
                  if (tick) begin
                     q <= q + 2'd1;
                     case (q)
                        2'd0: begin
                           if (last_bit) begin
                              sda_oe <= xfer_rd && !ack_last;
                           end else begin
                              sda_oe <= !xfer_rd && !shreg[7];
                           end
                        end
                        2'd1: scl_oe <= 1'b0;
                        2'd2: begin
                           if (last_bit) begin
                              nack_seen <= !xfer_rd && sda_s;
                           end else if (xfer_rd) begin
                              shreg <= {shreg[6:0], sda_s};
                           end
                        end
                        default: begin
                           scl_oe <= 1'b1;
                           if (!last_bit) begin
                              bit_idx <= bit_idx + 4'd1;
                              if (!xfer_rd) begin
                                 shreg <= {shreg[6:0], 1'b0};
                              end
                           end else begin
                              // SDA kept until the next quarter zero
                              if (xfer_rd) begin
                                 rx_data   <= shreg;
                                 recv_done <= 1'b1;
                                 state     <= ST_IDLE;
                                 cmd_ready <= 1'b1;
                              end else if (nack_seen) begin
                                 err_nack <= 1'b1;
                                 state    <= ST_STOP;
                              end else begin
                                 send_done <= 1'b1;
                                 addr_done <= 1'b1;
                                 state     <= ST_IDLE;
                                 cmd_ready <= 1'b1;
                              end
                           end
                        end
                     endcase
                  end
               end
               default: begin
                  state     <= ST_IDLE;
                  cmd_ready <= 1'b1;
               end
            endcase
         end
      end
   end

endmodule : pmbus_master_link

`default_nettype wire

//--- tb/pmbus_slave_model.sv
// Behavioural slave device on the open-drain serial bus
`timescale 1ns/100ps
`default_nettype none
module pmbus_slave_model (
   input  wire logic       scl,
   input  wire logic       sda,
   input  wire logic       nack_en,
   input  wire logic       stretch,
   input  wire logic       hold_low,
   input  wire logic       alert_req,
   input  wire logic [7:0] rd_base,
   output logic            scl_pull,
   output logic            sda_pull = 1'b0,
   output logic            smbalert_n,
   output logic [7:0]      got = 8'h00
);
   int         bitc = 0, nrd = 0;
   logic       rd = 1'b0, first = 1'b0, stall = 1'b0;
   logic [7:0] sh = 8'h00, rdv = 8'h00;
   assign scl_pull = hold_low | stall;
   assign smbalert_n = !alert_req;
   // Start or repeated start
   always @(negedge sda) if (scl === 1'b1) begin
      bitc = 0;
      rd = 1'b0;
      first = 1'b1;
      nrd = 0;
   end
   // Stop releases the data line and clears the bit and read state
   always @(posedge sda) if (scl === 1'b1) begin
      bitc = 0;
      rd = 1'b0;
      sda_pull = 1'b0;
   end
   always @(posedge scl) begin
      if (bitc < 8) sh = {sh[6:0], sda};
      else if (sda) rd = 1'b0;
      bitc = bitc + 1;
   end
   always @(negedge scl) begin
      if (bitc == 8) begin
         if (!rd) got = sh;
         sda_pull = !rd && !nack_en;
      end else if (bitc == 9) begin
         bitc = 0;
         if (first) rd = sh[0];
         first = 1'b0;
         rdv = rd_base + 8'(nrd);
         if (rd) nrd++;
         sda_pull = rd && !rdv[7];
         if (stretch) begin
            stall = 1'b1;
            #1500 stall = 1'b0;
         end
      end else if (rd && bitc > 0 && bitc < 8) sda_pull = !rdv[7 - bitc];
   end
endmodule : pmbus_slave_model
`default_nettype wire

//--- tb/pmbus_master_link_checker.sv
// Concurrent assertions on the ports of the bus master link
`timescale 1ns/100ps
`default_nettype none
module pmbus_master_link_checker
   import pmbus_link_pkg::*;
#(
   parameter int TIMEOUT_CYCLES = 2500000
) (
   input wire logic       mclk,
   input wire logic       sys_rst,
   input wire logic       cmd_valid,
   input wire logic [1:0] cmd,
   input wire logic       cmd_ready,
   input wire logic [7:0] rx_data,
   input wire logic       recv_done,
   input wire logic       send_done,
   input wire logic       err_nack,
   input wire logic       err_timeout,
   input wire logic       bus_active,
   input wire logic       scl_out,
   input wire logic       scl_oe,
   input wire logic       sda_out,
   input wire logic       sda_oe,
   input wire logic       control_in,
   input wire logic       control_pol,
   input wire logic       control_on,
   input wire logic       smbalert_n_in,
   input wire logic       alert
);
   int tcnt;
   // Cycles since the last byte event while the bus is held
   always_ff @(posedge mclk)
      if (sys_rst || !bus_active || send_done || recv_done || err_nack
          || err_timeout) tcnt <= 0;
      else tcnt <= tcnt + 1;
   int nack_age;
   // Cycles since a not-acknowledge while the bus is still held
   always_ff @(posedge mclk)
      if (sys_rst || !bus_active) nack_age <= 0;
      else if (err_nack) nack_age <= 1;
      else if (nack_age != 0) nack_age <= nack_age + 1;
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   a_pins_low:
      assert property (!scl_out && !sda_out) else $error("pin level high");
   a_take_busy:
      assert property (cmd_valid && cmd_ready && cmd != CMD_BYTE |=> ##1
         !cmd_ready) else $error("command taken but still ready");
   a_idle_free:
      assert property (cmd_ready && !bus_active |-> !scl_oe && !sda_oe)
      else $error("lines held while idle");
   a_rx_hold:
      assert property (!recv_done && !$past(sys_rst) |-> $stable(rx_data))
      else $error("read data changed without receive");
   a_nack_pulse:
      assert property (err_nack |-> bus_active && !send_done ##1 !err_nack)
      else $error("bad not-acknowledge pulse");
   a_nack_stop:
      assert property (nack_age <= 1100)
      else $error("no stop after not-acknowledge");
   a_tout_late:
      assert property (err_timeout |-> tcnt >= TIMEOUT_CYCLES - 4)
      else $error("timeout too early");
   a_tout_bound:
      assert property (tcnt <= TIMEOUT_CYCLES + 4) else $error("no timeout");
   a_ctrl_on:
      assert property ((control_in == control_pol && $stable(control_pol))
         [*4] |-> control_on)
      else $error("control not shown on");
   a_ctrl_off:
      assert property ((control_in != control_pol && $stable(control_pol))
         [*4] |-> !control_on)
      else $error("control not shown off");
   a_alert_follow:
      assert property ((!smbalert_n_in) [*4] |-> alert)
      else $error("alert not shown");
   c_send: cover property (send_done);
   c_recv: cover property (recv_done);
   c_nack: cover property (err_nack);
   c_tout: cover property (err_timeout);
endmodule : pmbus_master_link_checker
bind pmbus_master_link pmbus_master_link_checker #(
   .TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_chk (.mclk(mclk), .sys_rst(sys_rst),
   .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
   .rx_data(rx_data), .recv_done(recv_done), .send_done(send_done),
   .err_nack(err_nack), .err_timeout(err_timeout), .bus_active(bus_active),
   .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe),
   .control_in(control_in), .control_pol(control_pol),
   .control_on(control_on), .smbalert_n_in(smbalert_n_in), .alert(alert));
`default_nettype wire

//--- tb/test_pmbus_master_link.sv
// Self-checking bench for the bus master link with a slave model
`timescale 1ns/100ps
`default_nettype none
`include "pmbus_link_consts.svh"
module test_pmbus_master_link
   import pmbus_link_pkg::*;
;
   localparam int TOUT = 15000;
   localparam logic [1:0] EV_SEND = 2'h0, EV_RECV = 2'h1;
   localparam logic [1:0] EV_NACK = 2'h2, EV_TOUT = 2'h3;
   typedef struct packed {logic [1:0] kind; logic [7:0] data;} note_t;
   logic       mclk = 1'b0, sys_rst = 1'b1, cmd_valid = 1'b0, tx_valid = 1'b0;
   logic       cmd_last = 1'b0, control_in = 1'b0, control_pol = 1'b0;
   logic       nack_en = 1'b0, stretch = 1'b0, hold_low = 1'b0;
   logic       alert_req = 1'b0;
   logic [1:0] bus_speed = 2'h2, cmd = 2'h0;
   logic [7:0] tx_data = 8'h00, rd_base = 8'h00, a, base, code;
   wire logic  cmd_ready, tx_ready, recv_done, send_done, err_nack;
   wire logic  err_timeout, bus_active, scl_oe, sda_oe, control_on, alert;
   wire logic  scl_pull, sda_pull, smbalert_n;
   wire logic [7:0] rx_data, slv_got;
   wire logic  scl_w = !(scl_oe | scl_pull);
   wire logic  sda_w = !(sda_oe | sda_pull);
   wire logic [1:0] obs = recv_done ? EV_RECV : err_nack ? EV_NACK :
                          err_timeout ? EV_TOUT : EV_SEND;
   int         errors = 0, n_checks = 0, q;
   time        t0, per;
   note_t      notes[$], cur;

   always #5 mclk = !mclk;

   pmbus_master_link #(.TIMEOUT_CYCLES(TOUT)) dut (.mclk(mclk),
      .sys_rst(sys_rst), .bus_speed(bus_speed), .cmd_valid(cmd_valid),
      .cmd(cmd), .cmd_last(cmd_last), .cmd_ready(cmd_ready),
      .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .rx_data(rx_data), .recv_done(recv_done), .send_done(send_done),
      .err_nack(err_nack), .err_timeout(err_timeout),
      .bus_active(bus_active), .scl_in(scl_w), .scl_out(), .scl_oe(scl_oe),
      .sda_in(sda_w), .sda_out(), .sda_oe(sda_oe), .control_in(control_in),
      .control_pol(control_pol), .control_on(control_on),
      .smbalert_n_in(smbalert_n), .alert(alert));
   pmbus_slave_model slave (.scl(scl_w), .sda(sda_w), .nack_en(nack_en),
      .stretch(stretch), .hold_low(hold_low), .alert_req(alert_req),
      .rd_base(rd_base), .scl_pull(scl_pull), .sda_pull(sda_pull),
      .smbalert_n(smbalert_n), .got(slv_got));

   task automatic report(input logic [7:0] g, input logic [7:0] e);
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
   endtask : report
   task automatic chk_ev(input logic [1:0] g, input logic [1:0] e);
      n_checks++;
      if (g !== e) report({6'h0, g}, {6'h0, e});
   endtask : chk_ev
   task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
      n_checks++;
      if (g !== e) report(g, e);
   endtask : chk_byte
   task automatic chk_bit(input logic g, input logic e);
      n_checks++;
      if (g !== e) report({7'h0, g}, {7'h0, e});
   endtask : chk_bit

   // Results are matched against the oldest note
   always @(posedge mclk)
      if (!sys_rst && (send_done | recv_done | err_nack | err_timeout)) begin
         if (notes.size() == 0) report({6'h0, obs}, 8'hff);
         else begin
            cur = notes.pop_front();
            chk_ev(obs, cur.kind);
            if (cur.kind == EV_RECV) chk_byte(rx_data, cur.data);
         end
      end

   task automatic push_tx(input logic [7:0] d);
      @(posedge mclk);
      tx_data <= d;
      tx_valid <= 1'b1;
      do @(posedge mclk); while (tx_ready !== 1'b1);
      tx_valid <= 1'b0;
   endtask : push_tx
   task automatic run_cmd(input logic [1:0] c, input logic l, input int ev,
                          input logic [7:0] d);
      int n;
      n = 0;
      if (ev >= 0) notes.push_back({2'(ev), d});
      @(posedge mclk);
      cmd <= c;
      cmd_last <= l;
      cmd_valid <= 1'b1;
      do @(posedge mclk); while (cmd_ready !== 1'b1);
      cmd_valid <= 1'b0;
      repeat (2) @(posedge mclk);
      while (cmd_ready !== 1'b1 && n < 40000) begin
         @(posedge mclk);
         n++;
      end
      if (n >= 40000) report(8'h00, 8'h01);
      if (ev == EV_SEND) chk_byte(slv_got, d);
   endtask : run_cmd
   task automatic txn_write(input int nb);
      logic [7:0] b[$];
      for (int i = 0; i < nb; i++) begin
         b.push_back(i == 0 ? 8'($urandom) & 8'hfe : 8'($urandom));
         push_tx(b[i]);
      end
      repeat (2) @(posedge mclk);
      if (nb == 16) chk_bit(tx_ready, 1'b0);
      run_cmd(CMD_START, 1'b0, -1, 8'h00);
      for (int i = 0; i < nb; i++) run_cmd(CMD_BYTE, 1'b0, EV_SEND, b[i]);
      run_cmd(CMD_STOP, 1'b0, -1, 8'h00);
   endtask : txn_write
   task automatic complete_run;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : complete_run

   initial begin
      repeat (95000) @(posedge mclk);
      report(8'h00, 8'h01);
      complete_run();
   end

   initial begin
      void'($urandom(86));
      repeat (6) @(posedge mclk);
      sys_rst <= 1'b0;
      for (int s = 0; s < 4; s++) begin
         q = s == 1 ? `PML_Q400_CYC : s == 2 ? `PML_Q1M_CYC : `PML_Q100_CYC;
         bus_speed <= 2'(s);
         fork
            begin
               @(posedge scl_w);
               t0 = $time;
               @(posedge scl_w);
               per = $time - t0;
            end
         join_none
         txn_write(1);
         chk_bit(per >= 40 * q && per <= 40 * q + 80, 1'b1);
      end
      $display("test speed done");
      bus_speed <= SPD_1M;
      a = 8'($urandom) & 8'hfe;
      base = 8'($urandom);
      code = 8'($urandom);
      rd_base <= base;
      push_tx(a);
      push_tx(code);
      push_tx(a | 8'h01);
      run_cmd(CMD_START, 1'b0, -1, 8'h00);
      run_cmd(CMD_BYTE, 1'b0, EV_SEND, a);
      run_cmd(CMD_BYTE, 1'b0, EV_SEND, code);
      run_cmd(CMD_RSTART, 1'b0, -1, 8'h00);
      run_cmd(CMD_BYTE, 1'b0, EV_SEND, a | 8'h01);
      run_cmd(CMD_BYTE, 1'b0, EV_RECV, base);
      run_cmd(CMD_BYTE, 1'b1, EV_RECV, base + 8'h01);
      run_cmd(CMD_STOP, 1'b0, -1, 8'h00);
      chk_bit(bus_active, 1'b0);
      $display("test read done");
      nack_en <= 1'b1;
      push_tx(a);
      run_cmd(CMD_START, 1'b0, -1, 8'h00);
      run_cmd(CMD_BYTE, 1'b0, EV_NACK, a);
      chk_bit(bus_active, 1'b0);
      nack_en <= 1'b0;
      $display("test nack done");
      push_tx(a);
      run_cmd(CMD_START, 1'b0, -1, 8'h00);
      hold_low <= 1'b1;
      fork
         run_cmd(CMD_BYTE, 1'b0, EV_TOUT, a);
         begin
            do @(posedge mclk); while (err_timeout !== 1'b1);
            hold_low <= 1'b0;
         end
      join
      chk_bit(bus_active, 1'b0);
      $display("test timeout done");
      stretch <= 1'b1;
      txn_write(16);
      chk_bit(tx_ready, 1'b1);
      stretch <= 1'b0;
      $display("test fifo done");
      for (int i = 0; i < 8; i++) begin
         @(posedge mclk);
         {control_in, control_pol, alert_req} <= 3'($urandom);
         repeat (5) @(posedge mclk);
         chk_bit(control_on, control_in == control_pol);
         chk_bit(alert, alert_req);
      end
      $display("test pins done");
      chk_bit(notes.size() == 0, 1'b1);
      complete_run();
   end
endmodule : test_pmbus_master_link
`default_nettype wire
